// >>> pllc_core.sv
// serial programming, dividers, band select, lock detect and power control
`timescale 1ns/10ps
`include "pllc_regs.svh"
module pllc_core (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // serial programming
    input wire logic sclk_i,
    input wire logic sdata_i,
    input wire logic latch_strobe_i,
    input wire logic chip_enable_i,
    // reference input and prescaler output levels
    input wire logic ref_in_i,
    input wire logic fb_in_i,
    // prescaler and detector
    output logic modulus_high_o,
    output logic [1:0] prescaler_select_o,
    output logic half_rate_output_o,
    output logic half_rate_feed_select_o,
    output logic pfd_ref_o,
    output logic pfd_fb_o,
    output logic [1:0] antibacklash_width_o,
    output logic [2:0] pump_current_o,
    output logic pump_tristate_o,
    output logic detector_polarity_o,
    // oscillator and output stage
    output logic [1:0] core_current_o,
    output logic [1:0] output_level_o,
    output logic rf_enable_o,
    output logic tune_hold_o,
    // status
    output logic power_down_o,
    output logic digital_lock_o,
    output logic monitor_output_o,
    output logic monitor_output_oe_o
);
    // ***********************************************
    // input edges
    // ***********************************************
    logic [3:0] pins_reg;
    logic sclk_rise, strobe_rise, ref_rise, fb_rise;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pins_reg <= 4'h0;
        end else begin
            pins_reg <= {fb_in_i, ref_in_i, latch_strobe_i, sclk_i};
        end
    end

    assign sclk_rise = sclk_i & ~pins_reg[0];
    assign strobe_rise = latch_strobe_i & ~pins_reg[1];
    assign ref_rise = ref_in_i & ~pins_reg[2];
    assign fb_rise = fb_in_i & ~pins_reg[3];

    // ***********************************************
    // shift register and latches
    // ***********************************************
    logic [23:0] shift_reg, shift_next, ctl_reg, ctl_next;
    logic [23:0] ref_reg, ref_next, fb_reg, fb_next;
    logic [1:0] sel;
    logic ctl_write, fb_write;

    assign sel = shift_reg[1:0];
    assign ctl_write = strobe_rise && sel == `PLLC_SEL_CTRL;
    assign fb_write = strobe_rise && sel == `PLLC_SEL_FB;

    // serial side stays live in power-down
    always_comb begin
        shift_next = shift_reg;
        ctl_next = ctl_reg;
        ref_next = ref_reg;
        fb_next = fb_reg;
        if (sclk_rise) begin
            shift_next = {shift_reg[22:0], sdata_i};
        end
        if (strobe_rise) begin
            if (sel == `PLLC_SEL_CTRL) begin
                ctl_next = shift_reg;
            end else if (sel == `PLLC_SEL_REF) begin
                ref_next = shift_reg;
            end else if (sel == `PLLC_SEL_FB) begin
                fb_next = shift_reg;
            end
            // test words are dropped: no factory mode here
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_reg <= `PLLC_LATCH_RESET;
            ctl_reg <= `PLLC_LATCH_RESET;
            ref_reg <= `PLLC_LATCH_RESET;
            fb_reg <= `PLLC_LATCH_RESET;
        end else begin
            shift_reg <= shift_next;
            ctl_reg <= ctl_next;
            ref_reg <= ref_next;
            fb_reg <= fb_next;
        end
    end

    // ***********************************************
    // power control
    // ***********************************************
    pllc_pkg::pllc_pd_t pd_reg, pd_next;
    logic [1:0] pd_edges_reg, pd_edges_next;
    logic ref_pulse, fb_pulse, power_down, div_clear;

    // sync mode waits on reference pulses so the pump is not cut mid-cycle
    always_comb begin
        pd_next = pd_reg;
        pd_edges_next = pd_edges_reg;
        if (ctl_write) begin
            pd_edges_next = 2'h0;
            if (!shift_reg[`PLLC_CTL_PD_REQ]) begin
                pd_next = pllc_pkg::PD_ON;
            end else if (shift_reg[`PLLC_CTL_PD_SYNC]) begin
                pd_next = pllc_pkg::PD_ARMED;
            end else begin
                pd_next = pllc_pkg::PD_OFF;
            end
        end else begin
            case (pd_reg)
                pllc_pkg::PD_ARMED: begin
                    if (ref_pulse) begin
                        pd_edges_next = pd_edges_reg + 2'h1;
                        if (pd_edges_reg + 2'h1 == `PLLC_PD_SYNC_EDGES) begin
                            pd_next = pllc_pkg::PD_OFF;
                        end
                    end
                end
                default: begin
                    pd_next = pd_reg;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pd_reg <= pllc_pkg::PD_ON;
            pd_edges_reg <= 2'h0;
        end else begin
            pd_reg <= pd_next;
            pd_edges_reg <= pd_edges_next;
        end
    end

    assign power_down = !chip_enable_i || pd_reg == pllc_pkg::PD_OFF;
    assign div_clear = power_down || ctl_reg[`PLLC_CTL_CLR];

    // ***********************************************
    // dividers
    // ***********************************************
    logic band_tick;
    logic [3:0] band_ratio;
    logic [4:0] swallow_reg, swallow_next;

    pllc_divider #(.W(14)) ref_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(div_clear),
        .tick_i(ref_rise),
        .ratio_i(ref_reg[`PLLC_REF_CNT_HI:`PLLC_REF_CNT_LO]),
        .pulse_o(ref_pulse)
    );

    pllc_divider #(.W(13)) main_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(div_clear),
        .tick_i(fb_rise),
        .ratio_i(fb_reg[`PLLC_FB_B_HI:`PLLC_FB_B_LO]),
        .pulse_o(fb_pulse)
    );

    assign band_ratio = 4'h1 << ref_reg[`PLLC_REF_BSC_HI:`PLLC_REF_BSC_LO];

    pllc_divider #(.W(4)) band_div (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .clear_i(div_clear),
        .tick_i(ref_pulse),
        .ratio_i(band_ratio),
        .pulse_o(band_tick)
    );

    // first A prescaler cycles of each feedback period run at P+1
    always_comb begin
        swallow_next = swallow_reg;
        if (div_clear || fb_pulse) begin
            swallow_next = fb_reg[`PLLC_FB_A_HI:`PLLC_FB_A_LO];
        end else if (fb_rise && swallow_reg != 5'h00) begin
            swallow_next = swallow_reg - 5'h01;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            swallow_reg <= 5'h00;
        end else begin
            swallow_reg <= swallow_next;
        end
    end

    // ***********************************************
    // band selection
    // ***********************************************
    pllc_pkg::pllc_band_t band_reg, band_next;
    logic [2:0] band_cnt_reg, band_cnt_next;

    always_comb begin
        band_next = band_reg;
        band_cnt_next = band_cnt_reg;
        if (fb_write) begin
            band_next = pllc_pkg::BAND_RUN;
            band_cnt_next = 3'h0;
        end else begin
            case (band_reg)
                pllc_pkg::BAND_RUN: begin
                    if (band_tick) begin
                        band_cnt_next = band_cnt_reg + 3'h1;
                        if (band_cnt_reg + 3'h1 == `PLLC_BAND_TICKS) begin
                            band_next = pllc_pkg::BAND_IDLE;
                        end
                    end
                end
                default: begin
                    band_next = pllc_pkg::BAND_IDLE;
                end
            endcase
        end
    end

    // reset lands in the run state: selection at power-up
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            band_reg <= pllc_pkg::BAND_RUN;
            band_cnt_reg <= 3'h0;
        end else begin
            band_reg <= band_next;
            band_cnt_reg <= band_cnt_next;
        end
    end

    // ***********************************************
    // phase error and digital lock
    // ***********************************************
    logic win_reg, win_next, side_reg, side_next, lock_reg, lock_next;
    logic [7:0] err_reg, err_next, meas;
    logic [2:0] good_reg, good_next, need;
    logic eval, good, bad;

    assign need = ref_reg[`PLLC_REF_LDP] ? `PLLC_LOCK_CNT_HI
                                          : `PLLC_LOCK_CNT_LO;
    assign good = eval && meas < 8'(`PLLC_LOCK_CYC);
    assign bad = eval && meas > 8'(`PLLC_UNLOCK_CYC);

    // error measured in whole clock periods between the two edges
    always_comb begin
        win_next = win_reg;
        side_next = side_reg;
        err_next = err_reg;
        eval = 1'b0;
        meas = 8'h00;
        if (!win_reg) begin
            if (ref_pulse && fb_pulse) begin
                eval = 1'b1;
            end else if (ref_pulse || fb_pulse) begin
                win_next = 1'b1;
                side_next = ref_pulse;
                err_next = 8'h01;
            end
        end else if (side_reg ? fb_pulse : ref_pulse) begin
            eval = 1'b1;
            meas = err_reg;
            win_next = 1'b0;
        end else if (side_reg ? ref_pulse : fb_pulse) begin
            // same side twice: a missed edge counts as a gross error
            eval = 1'b1;
            meas = `PLLC_ERR_MAX;
            err_next = 8'h01;
        end else if (err_reg != `PLLC_ERR_MAX) begin
            err_next = err_reg + 8'h01;
        end
    end

    always_comb begin
        good_next = good_reg;
        lock_next = lock_reg;
        if (good) begin
            if (good_reg != 3'h7) begin
                good_next = good_reg + 3'h1;
            end
            if (good_reg + 3'h1 >= need) begin
                lock_next = 1'b1;
            end
        end else if (bad) begin
            good_next = 3'h0;
            lock_next = 1'b0;
        end else if (eval) begin
            good_next = 3'h0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            win_reg <= 1'b0;
            side_reg <= 1'b0;
            err_reg <= 8'h00;
            good_reg <= 3'h0;
            lock_reg <= 1'b0;
        end else if (power_down) begin
            win_reg <= 1'b0;
            side_reg <= 1'b0;
            err_reg <= 8'h00;
            good_reg <= 3'h0;
            lock_reg <= 1'b0;
        end else begin
            win_reg <= win_next;
            side_reg <= side_next;
            err_reg <= err_next;
            good_reg <= good_next;
            lock_reg <= lock_next;
        end
    end

    // ***********************************************
    // monitor output
    // ***********************************************
    logic mon_reg, mon_next, mon_oe_reg, mon_oe_next;

    always_comb begin
        mon_next = 1'b0;
        mon_oe_next = 1'b1;
        case (ctl_reg[`PLLC_CTL_MON_HI:`PLLC_CTL_MON_LO])
            3'h0: mon_oe_next = 1'b0;
            3'h1: mon_next = lock_reg;
            3'h2: mon_next = fb_pulse;
            3'h3: mon_next = 1'b1;
            3'h4: mon_next = ref_pulse;
            3'h5: mon_oe_next = lock_reg && win_reg;
            3'h6: mon_next = shift_reg[23];
            default: mon_next = 1'b0;
        endcase
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mon_reg <= 1'b0;
            mon_oe_reg <= 1'b0;
        end else begin
            mon_reg <= mon_next;
            mon_oe_reg <= mon_oe_next;
        end
    end

    // ***********************************************
    // outputs
    // ***********************************************
    assign modulus_high_o = swallow_reg != 5'h00;
    assign prescaler_select_o =
        ctl_reg[`PLLC_CTL_PRESC_HI:`PLLC_CTL_PRESC_LO];
    assign half_rate_output_o = fb_reg[`PLLC_FB_HALF];
    assign half_rate_feed_select_o = fb_reg[`PLLC_FB_FEED_SEL];
    assign pfd_ref_o = ref_pulse;
    assign pfd_fb_o = fb_pulse;
    assign antibacklash_width_o =
        ref_reg[`PLLC_REF_ABP_HI:`PLLC_REF_ABP_LO];
    assign pump_current_o = ctl_reg[`PLLC_CTL_GAIN]
        ? ctl_reg[`PLLC_CTL_CPI2_HI:`PLLC_CTL_CPI2_LO]
        : ctl_reg[`PLLC_CTL_PUMP_CURRENT_FIRST_FIELD_HI:`PLLC_CTL_PUMP_CURRENT_FIRST_FIELD_LO];
    assign pump_tristate_o = ctl_reg[`PLLC_CTL_TRI] || power_down;
    assign detector_polarity_o = ctl_reg[`PLLC_CTL_POL];
    assign core_current_o =
        ctl_reg[`PLLC_CTL_CORE_HI:`PLLC_CTL_CORE_LO];
    assign output_level_o =
        ctl_reg[`PLLC_CTL_LEVEL_HI:`PLLC_CTL_LEVEL_LO];
    assign rf_enable_o = !power_down &&
        (!ctl_reg[`PLLC_CTL_MUTE] || lock_reg);
    assign tune_hold_o = band_reg == pllc_pkg::BAND_RUN;
    assign power_down_o = power_down;
    assign digital_lock_o = lock_reg;
    assign monitor_output_o = mon_reg;
    assign monitor_output_oe_o = mon_oe_reg;

    // ***********************************************
    // checks
    // ***********************************************
    shift_in_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        sclk_rise |=> shift_reg[0] == $past(sdata_i)
            && shift_reg[23:1] == $past(shift_reg[22:0]))
        else $error("serial bit not shifted in");

    ctl_latch_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ctl_write |=> ctl_reg == $past(shift_reg) && $stable(fb_reg))
        else $error("control word not latched");

    test_drop_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        strobe_rise && sel == `PLLC_SEL_TEST |=> $stable(ctl_reg)
            && $stable(ref_reg) && $stable(fb_reg))
        else $error("test word altered a latch");

    lock_rise_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        $rose(lock_reg) |-> $past(good) && $past(good_reg) + 3'h1 >= $past(need))
        else $error("lock set without enough good cycles");

    lock_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        lock_reg && !bad && !power_down |=> lock_reg)
        else $error("lock dropped without large error");

    band_start_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        fb_write |=> tune_hold_o && band_cnt_reg == 3'h0)
        else $error("band select not started by feedback write");

    async_pd_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ctl_write && shift_reg[`PLLC_CTL_PD_REQ]
            && !shift_reg[`PLLC_CTL_PD_SYNC] |=> power_down_o)
        else $error("asynchronous power-down late");

    mute_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        ctl_reg[`PLLC_CTL_MUTE] && !lock_reg |-> !rf_enable_o)
        else $error("output enabled before lock while muted");

    chip_off_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        !chip_enable_i |-> power_down_o ##1 !lock_reg)
        else $error("chip enable low did not disable");
endmodule

// >>> pllc_regs.svh
// latch field positions, reset values and timing counts for the synth control
`ifndef PLLC_REGS_SVH
`define PLLC_REGS_SVH

// ***********************************************
// latch select codes (two lowest word bits)
// ***********************************************
`define PLLC_SEL_CTRL 2'h0
`define PLLC_SEL_REF 2'h1
`define PLLC_SEL_FB 2'h2
`define PLLC_SEL_TEST 2'h3
`define PLLC_WORD_W 24
`define PLLC_LATCH_RESET 24'h000000

// ***********************************************
// control word fields
// ***********************************************
`define PLLC_CTL_PRESC_HI 23
`define PLLC_CTL_PRESC_LO 22
`define PLLC_CTL_PD_SYNC 21
`define PLLC_CTL_PD_REQ 20
`define PLLC_CTL_CPI2_HI 19
`define PLLC_CTL_CPI2_LO 17
`define PLLC_CTL_PUMP_CURRENT_FIRST_FIELD_HI 16
`define PLLC_CTL_PUMP_CURRENT_FIRST_FIELD_LO 14
`define PLLC_CTL_LEVEL_HI 13
`define PLLC_CTL_LEVEL_LO 12
`define PLLC_CTL_MUTE 11
`define PLLC_CTL_GAIN 10
`define PLLC_CTL_TRI 9
`define PLLC_CTL_POL 8
`define PLLC_CTL_MON_HI 7
`define PLLC_CTL_MON_LO 5
`define PLLC_CTL_CLR 4
`define PLLC_CTL_CORE_HI 3
`define PLLC_CTL_CORE_LO 2

// ***********************************************
// reference and feedback word fields
// ***********************************************
`define PLLC_REF_BSC_HI 21
`define PLLC_REF_BSC_LO 20
`define PLLC_REF_LDP 18
`define PLLC_REF_ABP_HI 17
`define PLLC_REF_ABP_LO 16
`define PLLC_REF_CNT_HI 15
`define PLLC_REF_CNT_LO 2
`define PLLC_FB_FEED_SEL 23
`define PLLC_FB_HALF 22
`define PLLC_FB_B_HI 20
`define PLLC_FB_B_LO 8
`define PLLC_FB_A_HI 6
`define PLLC_FB_A_LO 2

// ***********************************************
// timing
// ***********************************************
`define PLLC_CLK_PERIOD_NS 50
`define PLLC_LOCK_WIN_NS 15
`define PLLC_UNLOCK_WIN_NS 25
`define PLLC_LOCK_CYC (((`PLLC_LOCK_WIN_NS / `PLLC_CLK_PERIOD_NS) < 1) ? 1 : (`PLLC_LOCK_WIN_NS / `PLLC_CLK_PERIOD_NS))
`define PLLC_UNLOCK_CYC (((`PLLC_UNLOCK_WIN_NS / `PLLC_CLK_PERIOD_NS) < 1) ? 1 : (`PLLC_UNLOCK_WIN_NS / `PLLC_CLK_PERIOD_NS))
`define PLLC_LOCK_CNT_LO 3'h3
`define PLLC_LOCK_CNT_HI 3'h5
`define PLLC_BAND_TICKS 3'h5
`define PLLC_PD_SYNC_EDGES 2'h2
`define PLLC_ERR_MAX 8'hFF

`endif

// >>> pllc_pkg.sv
// state types for the synth control block
package pllc_pkg;
    typedef enum logic [1:0] {
        BAND_IDLE = 2'b01,
        BAND_RUN = 2'b10
    } pllc_band_t;

    typedef enum logic [2:0] {
        PD_ON = 3'b001,
        PD_ARMED = 3'b010,
        PD_OFF = 3'b100
    } pllc_pd_t;
endpackage

// >>> pllc_divider.sv
// reloadable down-counting divider with a registered terminal pulse
`timescale 1ns/10ps
module pllc_divider #(
    parameter int W = 14
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // control
    input wire logic clear_i,
    input wire logic tick_i,
    input wire logic [W-1:0] ratio_i,
    // result
    output logic pulse_o
);
    logic [W-1:0] cnt_reg, cnt_next;
    logic pulse_reg, pulse_next;

    // ratio of zero behaves as one
    always_comb begin
        cnt_next = cnt_reg;
        pulse_next = 1'b0;
        if (clear_i) begin
            cnt_next = ratio_i;
        end else if (tick_i) begin
            if (cnt_reg <= W'(1)) begin
                cnt_next = ratio_i;
                pulse_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - W'(1);
            end
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cnt_reg <= '0;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse_o = pulse_reg;

    div_pulse_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
        pulse_reg |-> $past(tick_i) && !$past(clear_i))
        else $error("divider pulse without tick");
endmodule

// >>> pllc_host.sv
// serial programming host model for the synth control block
`timescale 1ns/10ps
module pllc_host (
    // clock
    input wire logic clk_i,
    // serial link
    output logic sclk_o,
    output logic sdata_o,
    output logic strobe_o
);
    initial begin
        sclk_o = 1'b0;
        sdata_o = 1'b0;
        strobe_o = 1'b0;
    end

    // msb first, so the select bits land lowest
    task automatic send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_i);
            #2 sclk_o = 1'b0;
            sdata_o = w[i];
            @(posedge clk_i);
            #2 sclk_o = 1'b1;
        end
        @(posedge clk_i);
        #2 sclk_o = 1'b0;
        // idle line must not look like a held bit
        sdata_o = ~w[0];
        @(posedge clk_i);
        #2 strobe_o = 1'b1;
        @(posedge clk_i);
        #2 strobe_o = 1'b0;
        repeat (2) @(posedge clk_i);
        #2;
    endtask
endmodule

// >>> tb.sv
// self-checking testbench for the synth control block
`timescale 1ns/10ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
    typedef struct packed {
        logic [1:0] p;
        logic [2:0] c2;
        logic [2:0] c1;
        logic [1:0] lv;
        logic g;
        logic pol;
        logic [1:0] core;
    } pllc_row_t;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic ce = 1'b1;
    logic ref_in = 1'b0;
    logic fb_in = 1'b0;
    logic fb_en = 1'b0;
    logic sclk, sdata, strobe;
    logic [1:0] presc, abw, core, lvl;
    logic [2:0] pump;
    logic half, feed, tri_st, pol, rfen, tune, pd, lock, mon, mon_oe;
    logic mod_hi, pref, pfb;
    int n_fail = 0;
    int checked = 0;
    int npul = 0;
    pllc_row_t rows [4] = '{'{2'h3, 3'h5, 3'h2, 2'h3, 1'b1, 1'b1, 2'h2},
        '{2'h1, 3'h2, 3'h7, 2'h1, 1'b0, 1'b0, 2'h1},
        '{2'h2, 3'h0, 3'h4, 2'h2, 1'b1, 1'b1, 2'h3},
        '{2'h0, 3'h7, 3'h0, 2'h0, 1'b0, 1'b0, 2'h0}};

    // monitor select 1 routes the digital lock out
    function automatic logic [23:0] ctl(pllc_row_t r, logic mt,
        logic [1:0] pdb);
        return {r.p, pdb, r.c2, r.c1, r.lv, mt, r.g, 1'b0, r.pol, 3'h1,
            1'b0, r.core, 2'h0};
    endfunction

    always #25 clk_i = ~clk_i;

    // feedback copies the reference so both dividers line up
    always begin
        repeat (4) @(posedge clk_i);
        #2 ref_in = ~ref_in;
        fb_in = fb_en & ref_in;
    end

    pllc_host host (.clk_i(clk_i), .sclk_o(sclk), .sdata_o(sdata),
        .strobe_o(strobe));

    pllc_core DUT (.clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk),
        .sdata_i(sdata), .latch_strobe_i(strobe), .chip_enable_i(ce),
        .ref_in_i(ref_in), .fb_in_i(fb_in), .modulus_high_o(mod_hi),
        .prescaler_select_o(presc), .half_rate_output_o(half),
        .half_rate_feed_select_o(feed), .pfd_ref_o(pref), .pfd_fb_o(pfb),
        .antibacklash_width_o(abw), .pump_current_o(pump),
        .pump_tristate_o(tri_st), .detector_polarity_o(pol),
        .core_current_o(core), .output_level_o(lvl), .rf_enable_o(rfen),
        .tune_hold_o(tune), .power_down_o(pd), .digital_lock_o(lock),
        .monitor_output_o(mon), .monitor_output_oe_o(mon_oe));

    task automatic wrap_up;
        if (n_fail == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // *******************
    // tests
    // *******************
    initial begin
        repeat (16) @(posedge clk_i);
        #2 reset_n_i = 1'b1;
        host.send({8'h02, 14'h0001, 2'h1});
        `CHK(abw, 2'h2)
        foreach (rows[i]) begin
            host.send(ctl(rows[i], 1'b0, 2'h0));
            `CHK(presc, rows[i].p)
            `CHK(core, rows[i].core)
            `CHK(lvl, rows[i].lv)
            `CHK(pol, rows[i].pol)
            `CHK(pump, rows[i].g ? rows[i].c2 : rows[i].c1)
        end
        host.send(24'hFFFFFF);
        `CHK(presc, rows[3].p)
        `CHK(abw, 2'h2)
        host.send({3'h4, 13'h0001, 1'b0, 5'h00, 2'h2});
        `CHK(feed, 1'b1)
        `CHK(half, 1'b0)
        `CHK(tune, 1'b1)
        repeat (16) @(posedge clk_i);
        #2 `CHK(tune, 1'b1)
        repeat (100) @(posedge clk_i);
        #2 `CHK(tune, 1'b0)
        host.send(ctl(rows[0], 1'b1, 2'h0));
        `CHK(rfen, 1'b0)
        ce = 1'b0;
        #1 `CHK(pd, 1'b1)
        @(posedge clk_i);
        #2 ce = 1'b1;
        fb_en = 1'b1;
        repeat (100) @(posedge clk_i);
        #2 `CHK(lock, 1'b1)
        `CHK(mon, 1'b1)
        `CHK(rfen, 1'b1)
        // ratio 1 on both sides: one pulse per 8 clocks, both together
        repeat (8) begin
            @(posedge clk_i);
            #2 `CHK(pfb, pref)
            npul += int'(pref);
        end
        `CHK(npul, 1)
        fb_en = 1'b0;
        repeat (40) @(posedge clk_i);
        #2 `CHK(lock, 1'b0)
        // band clock divided by 8: five ticks need 257 to 320 clocks
        host.send({8'h32, 14'h0001, 2'h1});
        host.send({3'h4, 13'h0001, 1'b0, 5'h00, 2'h2});
        repeat (100) @(posedge clk_i);
        #2 `CHK(tune, 1'b1)
        repeat (300) @(posedge clk_i);
        #2 `CHK(tune, 1'b0)
        host.send(ctl(rows[0], 1'b0, 2'h3));
        `CHK(pd, 1'b0)
        repeat (40) @(posedge clk_i);
        #2 `CHK(pd, 1'b1)
        `CHK(tri_st, 1'b1)
        host.send({8'h01, 14'h0001, 2'h1});
        `CHK(abw, 2'h1)
        host.send(ctl(rows[0], 1'b0, 2'h0));
        `CHK(pd, 1'b0)
        host.send(ctl(rows[0], 1'b0, 2'h1));
        `CHK(pd, 1'b1)
        // held down, so the swallow counter reloads every clock
        host.send({3'h4, 13'h0001, 1'b0, 5'h05, 2'h2});
        `CHK(mod_hi, 1'b1)
        host.send({3'h4, 13'h0001, 1'b0, 5'h00, 2'h2});
        `CHK(mod_hi, 1'b0)
        host.send(ctl(rows[0], 1'b0, 2'h1) | 24'h000040);
        `CHK(mon, 1'b1)
        `CHK(mon_oe, 1'b1)
        host.send(ctl(rows[0], 1'b0, 2'h1) | 24'h0000E0);
        `CHK(mon, 1'b0)
        `CHK(mon_oe, 1'b1)
        reset_n_i = 1'b0;
        #10 `CHK(tune, 1'b1)
        `CHK(presc, 2'h0)
        `CHK(mon_oe, 1'b0)
        @(posedge clk_i);
        #2 reset_n_i = 1'b1;
        wrap_up();
    end

    initial begin
        #500000;
        n_fail++;
        wrap_up();
    end
endmodule
